// [verilog/sawdt_defines.svh]
// offsets, fields, reset values and timing constants of the sleep-aware watchdog
// Operation
// - clear counter when device enters sleep
// - enabled in sleep: keep counting from zero
// - clear counter again when leaving sleep
// - timeout in sleep wakes, no reset
// - timeout updates timeout, powerdown, reset flags
// - hold cleared when mode off or soft-disabled
// - awake-only mode clears counter entering sleep
// - clear counter on sleep exit
// - oscillator divider change leaves counter alone
// - period select doubles ratio from 1:32
// - reserved period codes act as 1:32
// - period select resets to 1:65536
// - soft enable only counts in software mode
// - control bits 7:6 read zero
// - prescaler ticks from 31 kHz oscillator
// - mode bits: on, awake-only, software, off
// - clear on reset, clear instruction, osc fail
// - awake timeout without clear resets device
`ifndef SAWDT_DEFINES_SVH
`define SAWDT_DEFINES_SVH

`define SAWDT_CLK_HZ        40000000
`define SAWDT_LFOSC_HZ      31000
`define SAWDT_TICK_DIV      (`SAWDT_CLK_HZ / `SAWDT_LFOSC_HZ)
`define SAWDT_TICK_W        11

`define SAWDT_ADDR_W        12
`define SAWDT_OFF_CTRL      12'h000
`define SAWDT_OFF_CONFIG    12'h004
`define SAWDT_OFF_STATUS    12'h008
`define SAWDT_OFF_CMD       12'h00c
`define SAWDT_OFF_COUNT     12'h010

`define SAWDT_CTRL_PS       5:1
`define SAWDT_CTRL_SWEN     0
`define SAWDT_CFG_MODE      1:0
`define SAWDT_ST_TIMEOUT    0
`define SAWDT_ST_PWRDN      1
`define SAWDT_ST_WDRST      2
`define SAWDT_ST_ASLEEP     3
`define SAWDT_ST_ACTIVE     4
`define SAWDT_CMD_CLEAR     0

`define SAWDT_PS_RESET      5'h0b
`define SAWDT_SWEN_RESET    1'b0
`define SAWDT_CFG_RESET     2'h3

`define SAWDT_MODE_ON       2'h3
`define SAWDT_MODE_AWAKE    2'h2
`define SAWDT_MODE_SOFT     2'h1
`define SAWDT_MODE_OFF      2'h0

`define SAWDT_PS_MAX        5'h12
`define SAWDT_MIN_RATIO     24'h000020
`define SAWDT_CNT_W         23

`endif

// [verilog/sawdt_pkg.sv]
// types shared by the sleep-aware watchdog modules
`include "sawdt_defines.svh"
package sawdt_pkg;

  typedef enum logic {
    SAWDT_AWAKE,
    SAWDT_ASLEEP
  } sawdt_power_t;

  typedef struct packed {
    logic [`SAWDT_TICK_W-1:0] count;
    logic                     tick;
  } sawdt_tick_state_t;

  typedef struct packed {
    logic [4:0]               period_select;
    logic                     soft_enable;
    logic [1:0]               config_mode_bits;
    logic                     timeout_flag;
    logic                     powerdown_flag;
    logic                     wd_reset_flag;
    sawdt_power_t             power;
    logic [`SAWDT_CNT_W-1:0]  count;
    logic [31:0]              rdata;
    logic                     wdt_reset;
    logic                     wake;
  } sawdt_state_t;

endpackage

// [verilog/sawdt_tick_gen.sv]
// low-frequency oscillator tick: one-cycle enable every DIV system clocks
`timescale 1ns/1ps
`include "sawdt_defines.svh"
module sawdt_tick_gen #(
  parameter int unsigned DIV = `SAWDT_TICK_DIV
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  output logic      tick_out
);

  localparam logic [`SAWDT_TICK_W-1:0] LAST = `SAWDT_TICK_W'(DIV - 1);

  sawdt_pkg::sawdt_tick_state_t s_q;
  sawdt_pkg::sawdt_tick_state_t s_d;

  // free running: the watchdog time base never stops, even in sleep
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.count >= LAST) begin
      s_d.count = '0;
      s_d.tick  = 1'b1;
    end else begin
      s_d.count = s_q.count + `SAWDT_TICK_W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;

endmodule

// [verilog/sawdt_top.sv]
// sleep-aware watchdog timer with apb register slave
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "sawdt_defines.svh"
module sawdt_top #(
  parameter int unsigned TICK_DIV = `SAWDT_TICK_DIV
) (
  input  wire logic                     SYS_CLK_IN,
  input  wire logic                     RESET_IN,
  input  wire logic                     PSEL_IN,
  input  wire logic                     PENABLE_IN,
  input  wire logic                     PWRITE_IN,
  input  wire logic [`SAWDT_ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]              PWDATA_IN,
  output logic                          PREADY_OUT,
  output logic [31:0]                   PRDATA_OUT,
  output logic                          PSLVERR_OUT,
  input  wire logic                     SLEEP_ENTER_IN,
  input  wire logic                     WAKE_EVENT_IN,
  input  wire logic                     CLEAR_INSTR_IN,
  input  wire logic                     OSC_FAIL_IN,
  output logic                          WDT_RESET_OUT,
  output logic                          WAKE_OUT,
  output logic                          ASLEEP_OUT,
  output logic                          ACTIVE_OUT
);

  sawdt_pkg::sawdt_state_t s_q;
  sawdt_pkg::sawdt_state_t s_d;

  logic                    lf_tick;
  logic                    setup_ph;
  logic                    access_ph;
  logic                    mapped;
  logic                    wr_en;
  logic                    active;
  logic [4:0]              shift_amt;
  logic [23:0]             ratio;
  logic [`SAWDT_CNT_W-1:0] last;
  logic                    clear_now;
  logic                    timeout_now;
  logic [31:0]             rd_mux;
  logic [31:0]             w1c;

  sawdt_tick_gen #(
    .DIV      (TICK_DIV)
  ) u_tick (
    .clk_in   (SYS_CLK_IN),
    .rst_in   (RESET_IN),
    .tick_out (lf_tick)
  );

  // apb decode; every access completes with no wait state
  always_comb begin
    setup_ph  = PSEL_IN && !PENABLE_IN;
    access_ph = PSEL_IN && PENABLE_IN;
    case (PADDR_IN)
      `SAWDT_OFF_CTRL,
      `SAWDT_OFF_CONFIG,
      `SAWDT_OFF_STATUS,
      `SAWDT_OFF_CMD,
      `SAWDT_OFF_COUNT: mapped = 1'b1;
      default:          mapped = 1'b0;
    endcase
    wr_en = access_ph && PWRITE_IN && mapped;
  end

  // watchdog activity per mode and power state
  always_comb begin
    case (s_q.config_mode_bits)
      `SAWDT_MODE_ON:    active = 1'b1;
      `SAWDT_MODE_AWAKE: active = (s_q.power == sawdt_pkg::SAWDT_AWAKE);
      `SAWDT_MODE_SOFT:  active = s_q.soft_enable;
      `SAWDT_MODE_OFF:   active = 1'b0;
      default:           active = 1'b0;
    endcase
  end

  // terminal count: ratio of 32 doubled per code, reserved codes fold to 32
  always_comb begin
    if (s_q.period_select > `SAWDT_PS_MAX) begin
      shift_amt = 5'h00;
    end else begin
      shift_amt = s_q.period_select;
    end
    ratio = `SAWDT_MIN_RATIO << shift_amt;
    last  = `SAWDT_CNT_W'(ratio - 24'h000001);
  end

  always_comb begin
    clear_now = CLEAR_INSTR_IN || OSC_FAIL_IN
              || (wr_en && PADDR_IN == `SAWDT_OFF_CMD && PWDATA_IN[`SAWDT_CMD_CLEAR]);
    // at or past the end: a period shortened under a running count still fires
    timeout_now = active && !clear_now && lf_tick && (s_q.count >= last);
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR_IN)
      `SAWDT_OFF_CTRL: begin
        // bits 7:6 and above stay zero
        rd_mux[`SAWDT_CTRL_PS]   = s_q.period_select;
        rd_mux[`SAWDT_CTRL_SWEN] = s_q.soft_enable;
      end
      `SAWDT_OFF_CONFIG: begin
        rd_mux[`SAWDT_CFG_MODE] = s_q.config_mode_bits;
      end
      `SAWDT_OFF_STATUS: begin
        rd_mux[`SAWDT_ST_TIMEOUT] = s_q.timeout_flag;
        rd_mux[`SAWDT_ST_PWRDN]   = s_q.powerdown_flag;
        rd_mux[`SAWDT_ST_WDRST]   = s_q.wd_reset_flag;
        rd_mux[`SAWDT_ST_ASLEEP]  = (s_q.power == sawdt_pkg::SAWDT_ASLEEP);
        rd_mux[`SAWDT_ST_ACTIVE]  = active;
      end
      `SAWDT_OFF_COUNT: begin
        rd_mux[`SAWDT_CNT_W-1:0] = s_q.count;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    if (wr_en && PADDR_IN == `SAWDT_OFF_STATUS) begin
      w1c = PWDATA_IN;
    end else begin
      w1c = 32'h0000_0000;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.wdt_reset = 1'b0;
    s_d.wake      = 1'b0;

    // read data registered in the setup phase, held through access
    if (setup_ph) begin
      s_d.rdata = rd_mux;
    end

    // register writes; the divider of the cpu clock is not seen here at all
    if (wr_en && PADDR_IN == `SAWDT_OFF_CTRL) begin
      s_d.period_select = PWDATA_IN[`SAWDT_CTRL_PS];
      s_d.soft_enable   = PWDATA_IN[`SAWDT_CTRL_SWEN];
    end
    if (wr_en && PADDR_IN == `SAWDT_OFF_CONFIG) begin
      s_d.config_mode_bits = PWDATA_IN[`SAWDT_CFG_MODE];
    end

    // software clears flags by writing one; hardware set below wins
    if (w1c[`SAWDT_ST_TIMEOUT]) begin
      s_d.timeout_flag = 1'b0;
    end
    if (w1c[`SAWDT_ST_PWRDN]) begin
      s_d.powerdown_flag = 1'b0;
    end
    if (w1c[`SAWDT_ST_WDRST]) begin
      s_d.wd_reset_flag = 1'b0;
    end

    // counter: held clear while inactive, cleared on clear sources
    if (!active) begin
      s_d.count = '0;
    end else if (clear_now) begin
      s_d.count = '0;
    end else if (lf_tick) begin
      if (timeout_now) begin
        s_d.count = '0;
      end else begin
        s_d.count = s_q.count + `SAWDT_CNT_W'(1);
      end
    end

    if (timeout_now) begin
      s_d.timeout_flag = 1'b1;
      if (s_q.power == sawdt_pkg::SAWDT_ASLEEP) begin
        // wake instead of reset; leaving sleep clears the counter
        s_d.wake           = 1'b1;
        s_d.power          = sawdt_pkg::SAWDT_AWAKE;
        s_d.powerdown_flag = 1'b1;
        s_d.count          = '0;
      end else begin
        s_d.wdt_reset     = 1'b1;
        s_d.wd_reset_flag = 1'b1;
      end
    end else if (s_q.power == sawdt_pkg::SAWDT_AWAKE && SLEEP_ENTER_IN) begin
      s_d.power = sawdt_pkg::SAWDT_ASLEEP;
      s_d.count = '0;
    end else if (s_q.power == sawdt_pkg::SAWDT_ASLEEP && WAKE_EVENT_IN) begin
      // every system clock source counts as one that clears on exit
      s_d.power = sawdt_pkg::SAWDT_AWAKE;
      s_d.count = '0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      s_q                  <= '0;
      s_q.period_select    <= `SAWDT_PS_RESET;
      s_q.soft_enable      <= `SAWDT_SWEN_RESET;
      s_q.config_mode_bits <= `SAWDT_CFG_RESET;
      s_q.power            <= sawdt_pkg::SAWDT_AWAKE;
    end else begin
      s_q <= s_d;
    end
  end

  assign PREADY_OUT    = 1'b1;
  assign PSLVERR_OUT   = access_ph && !mapped;
  assign PRDATA_OUT    = s_q.rdata;
  assign WDT_RESET_OUT = s_q.wdt_reset;
  assign WAKE_OUT      = s_q.wake;
  assign ASLEEP_OUT    = (s_q.power == sawdt_pkg::SAWDT_ASLEEP);
  assign ACTIVE_OUT    = active;

endmodule

// [verification/sawdt_asserts.sv]
// port checker for the sleep-aware watchdog
`timescale 1ns/1ps
`include "sawdt_defines.svh"
module sawdt_asserts #(
  parameter int unsigned TICK_DIV = `SAWDT_TICK_DIV
) (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic SLEEP_ENTER_IN,
  input wire logic WAKE_EVENT_IN,
  input wire logic CLEAR_INSTR_IN,
  input wire logic OSC_FAIL_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic WDT_RESET_OUT,
  input wire logic WAKE_OUT,
  input wire logic ASLEEP_OUT
);
  logic [15:0] gap_q;
  // cycles since last timeout; a restart needs at least 31 ticks
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      gap_q <= 16'h0000;
    end else if (WDT_RESET_OUT || WAKE_OUT) begin
      gap_q <= 16'h0000;
    end else if (gap_q != 16'hffff) begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  a_ready_high: assert property (PREADY_OUT) else $error("ready low");
  a_err_access: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
    else $error("error outside access");
  a_wake_sleep: assert property (WAKE_OUT |-> $past(ASLEEP_OUT) && !ASLEEP_OUT)
    else $error("wake not from sleep");
  a_reset_awake: assert property (WDT_RESET_OUT |-> !$past(ASLEEP_OUT))
    else $error("reset while asleep");
  a_pulse_once: assert property ((WAKE_OUT || WDT_RESET_OUT) |=> !(WAKE_OUT || WDT_RESET_OUT))
    else $error("timeout pulse too long");
  a_sleep_enter: assert property (SLEEP_ENTER_IN && !ASLEEP_OUT |=> ASLEEP_OUT || WDT_RESET_OUT)
    else $error("sleep not entered");
  a_wake_event: assert property (ASLEEP_OUT && WAKE_EVENT_IN |=> !ASLEEP_OUT)
    else $error("sleep not left");
  a_clear_wins: assert property (CLEAR_INSTR_IN || OSC_FAIL_IN |=> !(WDT_RESET_OUT || WAKE_OUT))
    else $error("timeout despite clear");
  a_min_gap: assert property ((WDT_RESET_OUT || WAKE_OUT) |-> gap_q >= 31 * TICK_DIV)
    else $error("timeout too soon");
  c_wake: cover property (WAKE_OUT);
  c_reset: cover property (WDT_RESET_OUT);
  c_slverr: cover property (PSLVERR_OUT);
endmodule
bind sawdt_top sawdt_asserts #(.TICK_DIV(TICK_DIV)) u_sawdt_asserts (
  .SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .SLEEP_ENTER_IN(SLEEP_ENTER_IN), .WAKE_EVENT_IN(WAKE_EVENT_IN),
  .CLEAR_INSTR_IN(CLEAR_INSTR_IN), .OSC_FAIL_IN(OSC_FAIL_IN), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .WDT_RESET_OUT(WDT_RESET_OUT), .WAKE_OUT(WAKE_OUT),
  .ASLEEP_OUT(ASLEEP_OUT));

// [verification/sawdt_tb_top.sv]
// self-checking bench for the sleep-aware watchdog
`timescale 1ns/1ps
`include "sawdt_defines.svh"
module sawdt_tb_top;
  localparam int unsigned TD = 4;
  logic        clk, rst, psel, pen, pwr, slp, wk, clr, osc;
  logic        pready, perr, wrst, wake, asleep, act, errv;
  logic [11:0] paddr;
  logic [31:0] pwd, prd, rdv, lfsr;
  logic [4:0]  pl [7] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1f, 5'h00, 5'h00};
  logic [3:0]  mt [5] = '{4'b0010, 4'b0100, 4'b0111, 4'b1001, 4'b1101};
  int          mismatches, n_tests, n;
  sawdt_top #(.TICK_DIV(TD)) u_sawdt_top (
    .SYS_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwd), .PREADY_OUT(pready), .PRDATA_OUT(prd),
    .PSLVERR_OUT(perr), .SLEEP_ENTER_IN(slp), .WAKE_EVENT_IN(wk), .CLEAR_INSTR_IN(clr),
    .OSC_FAIL_IN(osc), .WDT_RESET_OUT(wrst), .WAKE_OUT(wake), .ASLEEP_OUT(asleep),
    .ACTIVE_OUT(act));
  always #12.5 clk = ~clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int ratio(input logic [4:0] ps);
    return (ps > 5'h12) ? 32 : 32 << ps;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no wait limit here: only the bench watchdog ends a stalled transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prd;
    errv = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // m is {clear, wake, sleep}
  task automatic ev(input logic [2:0] m);
    @(posedge clk);
    {clr, wk, slp} <= m;
    @(posedge clk);
    {clr, wk, slp} <= 3'h0;
  endtask
  // window is loose by three ticks below and two above: phase of the divider is not known
  task automatic wait_evt(input logic [4:0] ps, input logic er);
    n = 0;
    while (wrst !== 1'b1 && wake !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    chk("period", 1, n >= ratio(ps) * TD - 3 * TD && n <= ratio(ps) * TD + 2 * TD);
    chk("reset pulse", er, wrst);
    chk("wake pulse", !er, wake);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    mismatches++;
    give_verdict();
  end
  initial begin
    {clk, psel, pen, pwr, slp, wk, clr, osc, paddr, pwd} = '0;
    rst = 1'b1;
    lfsr = 32'h487d;
    mismatches = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(0, `SAWDT_OFF_CTRL, 0);
    chk("ctrl reset", 32'h16, rdv);
    apb(0, `SAWDT_OFF_CONFIG, 0);
    chk("config reset", 32'h3, rdv);
    apb(0, 12'h020, 0);
    chk("unmapped err", 1, errv);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      apb(1, `SAWDT_OFF_CTRL, lfsr);
      apb(0, `SAWDT_OFF_CTRL, 0);
      chk("ctrl bits", lfsr & 32'h3f, rdv);
    end
    pl[5] = 5'(lfsr % 3);
    pl[6] = 5'(19 + lfsr % 13);
    for (int i = 0; i < 7; i++) begin
      apb(1, `SAWDT_OFF_CTRL, {pl[i], 1'b0});
      apb(1, `SAWDT_OFF_CMD, 1);
      wait_evt(pl[i], 1);
    end
    apb(0, `SAWDT_OFF_STATUS, 0);
    chk("awake flags", 32'h15, rdv);
    apb(1, `SAWDT_OFF_STATUS, 7);
    repeat (40) @(posedge clk);
    apb(0, `SAWDT_OFF_COUNT, 0);
    chk("count runs", 1, rdv > 2);
    ev(3'h1);
    apb(0, `SAWDT_OFF_COUNT, 0);
    chk("sleep clear", 1, rdv < 2);
    wait_evt(0, 0);
    chk("woken", 0, asleep);
    apb(0, `SAWDT_OFF_STATUS, 0);
    chk("sleep flags", 32'h13, rdv);
    ev(3'h1);
    repeat (40) @(posedge clk);
    ev(3'h2);
    @(negedge clk);
    chk("wake event", 0, asleep);
    apb(0, `SAWDT_OFF_COUNT, 0);
    chk("exit clear", 1, rdv < 3);
    repeat (40) @(posedge clk);
    ev(3'h4);
    apb(0, `SAWDT_OFF_COUNT, 0);
    chk("clear instr", 1, rdv < 2);
    osc <= 1'b1;
    repeat (60) @(posedge clk);
    apb(0, `SAWDT_OFF_COUNT, 0);
    chk("osc fail", 0, rdv);
    osc <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      apb(1, `SAWDT_OFF_CTRL, mt[i][1]);
      apb(1, `SAWDT_OFF_CONFIG, mt[i][3:2]);
      repeat (40) @(posedge clk);
      apb(0, `SAWDT_OFF_STATUS, 0);
      chk("active bit", mt[i][0], rdv[4]);
      chk("active pin", mt[i][0], act);
      apb(0, `SAWDT_OFF_COUNT, 0);
      if (!mt[i][0]) chk("held count", 0, rdv);
    end
    apb(1, `SAWDT_OFF_CONFIG, 2);
    ev(3'h1);
    repeat (40) @(posedge clk);
    apb(0, `SAWDT_OFF_COUNT, 0);
    chk("awake-only sleep", 0, rdv);
    chk("awake-only pin", 0, act);
    ev(3'h2);
    // mid-run reset: registers back to reset values, counter cleared
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(0, `SAWDT_OFF_CTRL, 0);
    chk("ctrl re-reset", 32'h16, rdv);
    apb(0, `SAWDT_OFF_CONFIG, 0);
    chk("config re-reset", 32'h3, rdv);
    apb(0, `SAWDT_OFF_COUNT, 0);
    chk("reset clear", 1, rdv < 2);
    give_verdict();
  end
endmodule
